// ---- bench/aoc_output_cfg_tb.sv ----
// aoc_output_cfg_tb.sv: self-checking bench of the output config bank.
// assumes: design and aoc_rx_model compiled before this file.
`default_nettype none
module aoc_output_cfg_tb;
  import aoc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_clk = 0, i_rst_n = 0, i_sen_n = 1, i_sclk = 0;
  logic       i_sdata = 0, i_overrange = 0, i_narrow = 0, stall = 0;
  logic       i_sample_valid = 0, o_sample_ready, o_data_valid, rdy;
  logic       o_overrange_or_serial_out_pin, o_clk_drive_2x, o_data_drive_2x;
  logic [1:0] i_swing_en = 2'h3;
  logic [3:0] o_gain_half_db;
  logic [7:0] r;
  aoc_word_t  i_sample = 11'h000, o_data, last, w, v;
  aoc_swing_t o_swing;
  int         failures = 0, checks_done = 0, cnt, cy = 0, t0;
  logic [5:0] sc[5] = '{6'h00, 6'h1B, 6'h32, 6'h14, 6'h0F};
  aoc_swing_t sl[5] = '{AOC_SWING_350, AOC_SWING_410, AOC_SWING_465,
                        AOC_SWING_570, AOC_SWING_125};
  always #10 i_clk = ~i_clk;
  always @(posedge i_clk) cy <= cy + 1;
  aoc_output_cfg aoc_output_cfg_i (.i_clk, .i_rst_n, .i_sen_n, .i_sclk,
    .i_sdata, .i_overrange, .i_swing_en, .i_narrow, .i_sample,
    .i_sample_valid, .o_sample_ready, .o_data, .o_data_valid,
    .i_data_ready(rdy), .o_overrange_or_serial_out_pin, .o_swing, .o_gain_half_db,
    .o_clk_drive_2x, .o_data_drive_2x);
  aoc_rx_model aoc_rx_model_i (.i_clk, .i_rst_n, .i_stall(stall),
    .i_valid(o_data_valid), .i_data(o_data), .o_ready(rdy),
    .o_last(last), .o_cnt(cnt));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %0h got %0h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  // one 16-bit frame, msb first; shared pin sampled before each next rise
  task automatic xfer(logic [7:0] a, logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {a, d};
    i_sen_n <= 0;
    for (int k = 0; k < 16; k++) begin
      i_sdata <= f[15-k];
      cyc(4);
      i_sclk <= 1;
      cyc(4);
      i_sclk <= 0;
      cyc(4);
      if (k > 6 && k < 15) q[14-k] = o_overrange_or_serial_out_pin;
    end
    i_sen_n <= 1;
    cyc(6);
  endtask : xfer
  task automatic wr(logic [7:0] a, logic [7:0] d);
    logic [7:0] q;
    xfer(a, d, q);
  endtask : wr
  // offer one sample and wait, bounded, for the receiver to take a word
  task automatic put(aoc_word_t s, output aoc_word_t o);
    int n0;
    n0 = cnt;
    i_sample <= s;
    i_sample_valid <= 1;
    cyc(1);
    i_sample_valid <= 0;
    for (int t = 0; t < 50 && cnt == n0; t++) cyc(1);
    if (cnt == n0) begin
      failures++;
      wrap_up();
    end
    o = last;
  endtask : put
  ////////////////////////////////////////////////////////////////////////
  // watchdog: a hang counts as a mismatch
  initial begin
    cyc(40000);
    failures++;
    wrap_up();
  end
  // defaults straight after reset
  task automatic t_defaults();
    chk("swing", o_swing, AOC_SWING_350);
    chk("gain", o_gain_half_db, 0);
    chk("drive", {o_clk_drive_2x, o_data_drive_2x}, 0);
  endtask : t_defaults
  // every swing code, then the enable gate
  task automatic t_swing();
    for (int i = 0; i < 5; i++) begin
      wr(8'h01, {sc[i], 2'h0});
      chk("swing", o_swing, sl[i]);
    end
    wr(8'h01, 8'h6C);
    i_swing_en <= 2'h1;
    cyc(2);
    chk("swing gated", o_swing, AOC_SWING_350);
    i_swing_en <= 2'h3;
  endtask : t_swing
  // gain codes and both drive bits
  task automatic t_gain_drive();
    for (int c = 5; c < 13; c++) begin
      wr(8'h25, 8'(c << 4));
      chk("gain", o_gain_half_db, c - 5);
    end
    wr(8'h26, 8'h02);
    chk("drive", {o_clk_drive_2x, o_data_drive_2x}, 2);
    wr(8'h26, 8'h01);
    chk("drive", {o_clk_drive_2x, o_data_drive_2x}, 1);
  endtask : t_gain_drive
  // readback of a mapped and an unmapped address
  task automatic t_readback();
    wr(8'h00, 8'h01);
    xfer(8'h25, 8'hC0, r);
    chk("readback", r, 8'hC0);
    xfer(8'h50, 8'h00, r);
    chk("unmapped", r, 8'h00);
  endtask : t_readback
  // soft reset, shared pin levels, reset bit reads back zero
  task automatic t_soft_reset();
    wr(8'h00, 8'h02);
    chk("gain", o_gain_half_db, 0);
    chk("swing", o_swing, AOC_SWING_350);
    chk("drive", {o_clk_drive_2x, o_data_drive_2x}, 0);
    i_overrange <= 1;
    cyc(3);
    chk("ovr pin", o_overrange_or_serial_out_pin, 1);
    i_overrange <= 0;
    cyc(3);
    chk("ovr pin", o_overrange_or_serial_out_pin, 0);
    wr(8'h00, 8'h01);
    xfer(8'h00, 8'h01, r);
    chk("reset bit", r, 8'h01);
    wr(8'h00, 8'h00);
  endtask : t_soft_reset
  // sample, fixed, custom and toggle patterns
  task automatic t_patterns();
    put(11'h3C5, w);
    chk("normal", w, 11'h3C5);
    wr(8'h25, 8'h01);
    put(11'h7FF, w);
    chk("zeros", w, 11'h000);
    wr(8'h25, 8'h02);
    put(11'h000, w);
    chk("ones", w, 11'h7FF);
    wr(8'h3F, 8'hA5);
    wr(8'h40, 8'h60);
    wr(8'h25, 8'h05);
    put(11'h000, w);
    chk("custom", w, 11'h52B);
    wr(8'h25, 8'h03);
    put(11'h000, w);
    put(11'h000, v);
    chk("toggle", {w, v}, {11'h2AA, 11'h555});
    i_narrow <= 1;
    wr(8'h25, 8'h00);
    wr(8'h25, 8'h03);
    put(11'h000, w);
    put(11'h000, v);
    chk("toggle9", {w, v}, {11'h0AA, 11'h155});
    i_narrow <= 0;
  endtask : t_patterns
  // receiver stall fills both entries, then drains
  task automatic t_stall();
    wr(8'h25, 8'h00);
    t0 = cnt;
    stall <= 1;
    i_sample <= 11'h123;
    i_sample_valid <= 1;
    cyc(3);
    i_sample_valid <= 0;
    chk("full", o_sample_ready, 0);
    stall <= 0;
    cyc(4);
    chk("drained", cnt - t0, 2);
  endtask : t_stall
  // ramp rate over sixteen cycles and wrap after a full sweep
  task automatic t_ramp();
    wr(8'h25, 8'h04);
    t0 = cy;
    put(11'h000, w);
    while (cy < t0 + 16) cyc(1);
    t0 = cy;
    put(11'h000, v);
    chk("ramp", v, w + 2);
    while (cy < t0 + 16384) cyc(1);
    put(11'h000, w);
    chk("ramp wrap", w, v);
  endtask : t_ramp
  // main sequence
  initial begin
    cyc(12);
    i_rst_n <= 1;
    cyc(6);
    t_defaults();
    t_swing();
    t_gain_drive();
    t_readback();
    t_soft_reset();
    t_patterns();
    t_stall();
    t_ramp();
    wrap_up();
  end
endmodule : aoc_output_cfg_tb
`default_nettype wire

// ---- bench/aoc_rx_model.sv ----
// aoc_rx_model.sv: receiver logic that captures output words.
// assumes: shares the block clock; the bench commands any stall.
`default_nettype none
module aoc_rx_model
  import aoc_pkg::*;
(
  input  wire logic      i_clk,    // clock
  input  wire logic      i_rst_n,  // sync reset, low active
  input  wire logic      i_stall,  // hold off taking words
  input  wire logic      i_valid,  // word valid
  input  wire aoc_word_t i_data,   // word offered
  output logic           o_ready,  // takes the word
  output aoc_word_t      o_last,   // last word taken
  output var int         o_cnt     // words taken
);
  timeunit 1ns;
  timeprecision 1ps;
  // stalls only when told to, so no word is ever dropped here
  assign o_ready = !i_stall;
  // capture each word on the edge it is taken
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cnt <= 0;
    end else if (i_valid && o_ready) begin
      o_last <= i_data;
      o_cnt  <= o_cnt + 1;
    end
  end
endmodule : aoc_rx_model
`default_nettype wire

// ---- src/aoc_map.svh ----
// aoc_map.svh: offsets, field positions, reset values, codes and counts
// of the converter output configuration bank.
// assumes: included by bare name from the package and the modules.
`ifndef AOC_MAP_SVH
`define AOC_MAP_SVH

// register offsets on the serial programming port
`define AOC_ADDR_RST      8'h00
`define AOC_ADDR_SWING    8'h01
`define AOC_ADDR_GAIN     8'h25
`define AOC_ADDR_DRIVE    8'h26
`define AOC_ADDR_CUST_HI  8'h3F
`define AOC_ADDR_CUST_LO  8'h40

// field positions
`define AOC_RST_BIT       1
`define AOC_RDO_BIT       0
`define AOC_SWING_LSB     2
`define AOC_GAIN_LSB      4
`define AOC_PAT_LSB       0
`define AOC_CLKDRV_BIT    1
`define AOC_DATDRV_BIT    0
`define AOC_CUST_LO_LSB   5

// reset values
`define AOC_RST_SWING     6'h00
`define AOC_RST_GAIN      4'h0
`define AOC_RST_PAT       3'h0
`define AOC_RST_DRIVE     2'h0
`define AOC_RST_CUST_HI   8'h00
`define AOC_RST_CUST_LO   3'h0

// swing codes
`define AOC_SW_DEFAULT    6'h00
`define AOC_SW_410        6'h1B
`define AOC_SW_465        6'h32
`define AOC_SW_570        6'h14
`define AOC_SW_125        6'h0F

// gain codes: first and last stepped code, and offset to half-dB steps
`define AOC_GAIN_FIRST    4'h6
`define AOC_GAIN_LAST     4'hC
`define AOC_GAIN_OFS      4'h5

// test pattern codes
`define AOC_PAT_NORMAL    3'h0
`define AOC_PAT_ZEROS     3'h1
`define AOC_PAT_ONES      3'h2
`define AOC_PAT_TOGGLE    3'h3
`define AOC_PAT_RAMP      3'h4
`define AOC_PAT_CUSTOM    3'h5

// toggle words, full and narrow variant
`define AOC_TOG_A         11'h2AA
`define AOC_TOG_B         11'h555
`define AOC_TOG9_A        9'h0AA
`define AOC_TOG9_B        9'h155

// ramp advances when the divider reaches this count (last of eight phases)
`define AOC_RAMP_LAST     3'h7

// serial frame: bit index of last address bit and of last data bit
`define AOC_FRM_ADDR_END  4'h7
`define AOC_FRM_LAST      4'hF

`endif

// ---- src/aoc_output_cfg.sv ----
// aoc_output_cfg.sv: output configuration bank of the converter with
// its serial programming port, readback, swing, gain, drive strength
// and check pattern data path.
// assumes: serial pins come from outside the clock domain; samples,
// overrange and straps come from logic on i_clk.
`default_nettype none
`include "aoc_map.svh"

// Notes on behaviour
// [RULE1] soft reset restores defaults, then self-clears
// [RULE2] readback off: shared pin shows overrange
// [RULE3] readback on: shared pin shifts register data
// [RULE4] swing codes decode to five levels
// [RULE5] swing applies only with enable bits set
// [RULE6] gain field bits 7:4, reset 0dB
// [RULE7] gain codes 6..12 give half-dB steps
// [RULE8] pattern 000 passes converted samples
// [RULE9] pattern 001 all zeros, 010 all ones
// [RULE10] pattern 011 alternates 11-bit toggle words
// [RULE11] narrow variant alternates 9-bit toggle words
// [RULE12] pattern 100 ramps every eighth cycle
// [RULE13] pattern 101 outputs custom register word
// [RULE14] host writes zero to reserved bits
// [RULE15] custom word high from 3Fh, low 40h
// [RULE16] drive bits select doubled clock/data strength
// [RULE17] host avoids unused pattern codes 110, 111
// [RULE18] ramp wraps to zero at same rate
module aoc_output_cfg
  import aoc_pkg::*;
(
  input  wire logic       i_clk,           // 50 MHz clock
  input  wire logic       i_rst_n,         // sync reset, low active
  input  wire logic       i_sen_n,         // serial enable, low active
  input  wire logic       i_sclk,          // serial clock pin
  input  wire logic       i_sdata,         // serial data in
  input  wire logic       i_overrange,     // overrange indication
  input  wire logic [1:0] i_swing_en,      // swing-control enables
  input  wire logic       i_narrow,        // 9-bit variant strap
  input  wire aoc_word_t  i_sample,        // converted sample
  input  wire logic       i_sample_valid,  // sample valid
  output logic            o_sample_ready,  // room for a sample
  output aoc_word_t       o_data,          // output data word
  output logic            o_data_valid,    // output word valid
  input  wire logic       i_data_ready,    // receiver takes word
  output logic            o_overrange_or_serial_out_pin,     // overrange_or_serial_out_pin
  output aoc_swing_t      o_swing,         // effective swing level
  output logic [3:0]      o_gain_half_db,  // gain in 0.5 dB steps
  output logic            o_clk_drive_2x,  // clock_output_drive_strength
  output logic            o_data_drive_2x  // data output doubled drive
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers: three stages, a change counts when 2 and 3 agree

  logic [2:0] pins;                        // {sen_n, sclk, sdata}
  logic [2:0] s1_q, s2_q, s3_q;            // stage flops
  logic [2:0] filt_q, filt_d;              // accepted pin levels
  logic [2:0] prev_q;                      // accepted levels, last cycle

  assign pins = {i_sen_n, i_sclk, i_sdata};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      // accept a new level only once two late stages agree
      always_comb begin
        filt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : filt_q[g];
      end
    end
  endgenerate

  // register synchroniser stages; idle pins read enable high
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s1_q   <= 3'h4;
      s2_q   <= 3'h4;
      s3_q   <= 3'h4;
      filt_q <= 3'h4;
      prev_q <= 3'h4;
    end else begin
      s1_q   <= pins;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
      prev_q <= filt_q;
    end
  end

  logic sen_act;                           // frame in progress
  logic sclk_rise;                         // accepted rising edge
  assign sen_act   = ~filt_q[2];
  assign sclk_rise = filt_q[1] & ~prev_q[1];

  ////////////////////////////////////////////////////////////////////
  // serial frame: 8 address bits then 8 data bits, msb first

  logic [3:0]  cnt_q, cnt_d;               // bit index in frame
  logic [14:0] sh_q, sh_d;                 // bits received so far
  logic [7:0]  rd_q, rd_d;                 // readback shifter
  logic [15:0] word;                       // frame incl. current bit
  logic        wr_en;                      // frame complete
  logic [7:0]  rd_val;                     // readback value by address

  assign word  = {sh_q, filt_q[0]};
  assign wr_en = sen_act & sclk_rise & (cnt_q == `AOC_FRM_LAST);

  // next frame state
  always_comb begin
    cnt_d = cnt_q;
    sh_d  = sh_q;
    rd_d  = rd_q;
    if (!sen_act) begin
      cnt_d = '0;
      rd_d  = '0;
    end else if (sclk_rise) begin
      cnt_d = cnt_q + 4'h1;
      sh_d  = word[14:0];
      if (cnt_q == `AOC_FRM_ADDR_END) begin
        rd_d = rd_val;                     // load at last address bit
      end else if (cnt_q > `AOC_FRM_ADDR_END) begin
        rd_d = {rd_q[6:0], 1'b0};          // next bit after each edge
      end
    end
  end

  // register frame state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
      sh_q  <= '0;
      rd_q  <= '0;
    end else begin
      cnt_q <= cnt_d;
      sh_q  <= sh_d;
      rd_q  <= rd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register file

  logic [5:0] swing_q, swing_d;            // output_swing_control field
  logic [3:0] gain_q, gain_d;              // gain field
  logic [2:0] pat_q, pat_d;                // capture_check_pattern field
  logic [1:0] drive_q, drive_d;            // output_drive_strength bits
  logic [7:0] chi_q, chi_d;                // custom word bits 10:3
  logic [2:0] clo_q, clo_d;                // custom word bits 2:0
  logic       rdo_q, rdo_d;                // serial readback enable
  logic       srst_q, srst_d;              // soft reset pending
  logic [7:0] waddr, wdata;                // write address and data

  assign waddr = word[15:8];
  assign wdata = word[7:0];

  // next register values; reserved bits are not stored
  always_comb begin
    swing_d = swing_q;
    gain_d  = gain_q;
    pat_d   = pat_q;
    drive_d = drive_q;
    chi_d   = chi_q;
    clo_d   = clo_q;
    rdo_d   = rdo_q;
    srst_d  = 1'b0;                                        // RULE1
    if (srst_q) begin
      swing_d = `AOC_RST_SWING;                            // RULE1
      gain_d  = `AOC_RST_GAIN;                             // RULE6
      pat_d   = `AOC_RST_PAT;
      drive_d = `AOC_RST_DRIVE;
      chi_d   = `AOC_RST_CUST_HI;
      clo_d   = `AOC_RST_CUST_LO;
      rdo_d   = 1'b0;
    end else if (wr_en) begin
      case (waddr)
        `AOC_ADDR_RST: begin
          srst_d = wdata[`AOC_RST_BIT];                    // RULE1
          rdo_d  = wdata[`AOC_RDO_BIT];
        end
        `AOC_ADDR_SWING:   swing_d = wdata[`AOC_SWING_LSB +: 6];
        `AOC_ADDR_GAIN: begin
          gain_d = wdata[`AOC_GAIN_LSB +: 4];              // RULE6
          pat_d  = wdata[`AOC_PAT_LSB +: 3];
        end
        `AOC_ADDR_DRIVE:   drive_d = wdata[1:0];           // RULE16
        `AOC_ADDR_CUST_HI: chi_d = wdata;                  // RULE15
        `AOC_ADDR_CUST_LO: clo_d = wdata[`AOC_CUST_LO_LSB +: 3]; // RULE15
        default: ;
      endcase
    end
  end

  // register file flops
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      swing_q <= `AOC_RST_SWING;
      gain_q  <= `AOC_RST_GAIN;
      pat_q   <= `AOC_RST_PAT;
      drive_q <= `AOC_RST_DRIVE;
      chi_q   <= `AOC_RST_CUST_HI;
      clo_q   <= `AOC_RST_CUST_LO;
      rdo_q   <= 1'b0;
      srst_q  <= 1'b0;
    end else begin
      swing_q <= swing_d;
      gain_q  <= gain_d;
      pat_q   <= pat_d;
      drive_q <= drive_d;
      chi_q   <= chi_d;
      clo_q   <= clo_d;
      rdo_q   <= rdo_d;
      srst_q  <= srst_d;
    end
  end

  // readback value; reserved bits and reset bit read as zero
  always_comb begin
    case (word[7:0])
      `AOC_ADDR_RST:     rd_val = {7'h00, rdo_q};
      `AOC_ADDR_SWING:   rd_val = {swing_q, 2'h0};
      `AOC_ADDR_GAIN:    rd_val = {gain_q, 1'b0, pat_q};
      `AOC_ADDR_DRIVE:   rd_val = {6'h00, drive_q};
      `AOC_ADDR_CUST_HI: rd_val = chi_q;
      `AOC_ADDR_CUST_LO: rd_val = {clo_q, 5'h00};
      default:           rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // shared pin, swing, gain and drive outputs

  logic ovr_q, ovr_d;                      // shared pin flop

  // pin shows overrange or the readback bit
  always_comb begin
    ovr_d = rdo_q ? rd_q[7] : i_overrange;                 // RULE2 RULE3
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_d;
    end
  end

  assign o_overrange_or_serial_out_pin = ovr_q;

  // swing decode, held at default until both enables are set
  always_comb begin
    o_swing = AOC_SWING_350;
    if (&i_swing_en) begin                                 // RULE5
      case (swing_q)
        `AOC_SW_410: o_swing = AOC_SWING_410;              // RULE4
        `AOC_SW_465: o_swing = AOC_SWING_465;
        `AOC_SW_570: o_swing = AOC_SWING_570;
        `AOC_SW_125: o_swing = AOC_SWING_125;
        default:     o_swing = AOC_SWING_350;
      endcase
    end
  end

  // gain decode; codes outside the stepped range give 0 dB
  always_comb begin
    o_gain_half_db = 4'h0;                                 // RULE6
    if (gain_q >= `AOC_GAIN_FIRST && gain_q <= `AOC_GAIN_LAST) begin
      o_gain_half_db = gain_q - `AOC_GAIN_OFS;             // RULE7
    end
  end

  assign o_clk_drive_2x  = drive_q[`AOC_CLKDRV_BIT];      // RULE16
  assign o_data_drive_2x = drive_q[`AOC_DATDRV_BIT];      // RULE16

  ////////////////////////////////////////////////////////////////////
  // data path: pattern select, then two-entry buffer

  aoc_word_t custom;                       // assembled custom word
  aoc_word_t pat_word;                     // word toward buffer
  assign custom = {chi_q, clo_q};                          // RULE15

  aoc_pattern_gen u_pat (
    .i_clk    (i_clk),
    .i_rst_n  (i_rst_n),
    .i_pat    (pat_q),
    .i_narrow (i_narrow),
    .i_custom (custom),
    .i_sample (i_sample),
    .i_take   (i_sample_valid & o_sample_ready),
    .o_word   (pat_word)
  );

  aoc_skid2 #(.W(11)) u_buf (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_data  (pat_word),
    .i_valid (i_sample_valid),
    .o_ready (o_sample_ready),
    .o_data  (o_data),
    .o_valid (o_data_valid),
    .i_ready (i_data_ready)
  );

  ////////////////////////////////////////////////////////////////////
  // checks

  sequence s_soft_rst_write;
    wr_en && waddr == `AOC_ADDR_RST && wdata[`AOC_RST_BIT];
  endsequence

  a_soft_rst_clear: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE1
    s_soft_rst_write |=> srst_q ##1 (!srst_q && gain_q == 4'h0
      && pat_q == 3'h0 && swing_q == 6'h00 && !rdo_q))
    else $error("soft reset did not restore defaults");

  a_pin_overrange: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE2
    !rdo_q |=> o_overrange_or_serial_out_pin == $past(i_overrange))
    else $error("shared pin not showing overrange");

  a_pin_readback: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE3
    rdo_q |=> o_overrange_or_serial_out_pin == $past(rd_q[7]))
    else $error("shared pin not showing readback data");

  a_swing_gate: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE5
    !(&i_swing_en) |-> o_swing == AOC_SWING_350)
    else $error("swing applied without enables");

  a_swing_code: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE4
    &i_swing_en && swing_q == 6'h0F |-> o_swing == AOC_SWING_125)
    else $error("swing code 001111 misdecoded");

  a_gain_steps: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE7
    gain_q == 4'hC |-> o_gain_half_db == 4'h7)
    else $error("gain code 1100 misdecoded");

  a_custom_word: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE13
    pat_q == 3'h5 |-> pat_word == {chi_q, clo_q})
    else $error("custom pattern word wrong");

  a_normal_data: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE8
    pat_q == 3'h0 && i_sample_valid && o_sample_ready && !o_data_valid
      |=> o_data == $past(i_sample))
    else $error("sample not passed in normal mode");

endmodule : aoc_output_cfg
`default_nettype wire

// ---- src/aoc_pattern_gen.sv ----
// aoc_pattern_gen.sv: chooses between sample data and check patterns.
// assumes: i_take pulses once per sample accepted downstream.
`default_nettype none
`include "aoc_map.svh"
module aoc_pattern_gen
  import aoc_pkg::*;
(
  input  wire logic       i_clk,     // clock
  input  wire logic       i_rst_n,   // sync reset, low active
  input  wire logic [2:0] i_pat,     // capture_check_pattern code
  input  wire logic       i_narrow,  // 9-bit variant
  input  wire aoc_word_t  i_custom,  // user word
  input  wire aoc_word_t  i_sample,  // converted sample
  input  wire logic       i_take,    // sample accepted
  output aoc_word_t       o_word     // word toward the buffer
);
  logic       tog_q, tog_d;          // toggle phase
  logic [2:0] div_q, div_d;          // eighth-cycle divider
  aoc_word_t  ramp_q, ramp_d;        // ramp value
  logic       is_ramp;               // ramp selected

  assign is_ramp = (i_pat == `AOC_PAT_RAMP);

  // next pattern state
  always_comb begin
    tog_d  = tog_q;
    div_d  = '0;
    ramp_d = '0;
    if (i_pat != `AOC_PAT_TOGGLE) begin
      tog_d = 1'b0;
    end else if (i_take) begin
      tog_d = ~tog_q;                                      // RULE10 RULE11
    end
    if (is_ramp) begin
      div_d  = div_q + 3'h1;
      ramp_d = ramp_q;
      if (div_q == `AOC_RAMP_LAST) begin
        ramp_d = ramp_q + 11'h001;                         // RULE12 RULE18
      end
    end
  end

  // output word selection
  always_comb begin
    case (i_pat)
      `AOC_PAT_NORMAL: o_word = i_sample;                  // RULE8
      `AOC_PAT_ZEROS:  o_word = '0;                        // RULE9
      `AOC_PAT_ONES:   o_word = '1;                        // RULE9
      `AOC_PAT_TOGGLE: begin
        if (i_narrow) begin
          o_word = {2'h0, tog_q ? `AOC_TOG9_B : `AOC_TOG9_A}; // RULE11
        end else begin
          o_word = tog_q ? `AOC_TOG_B : `AOC_TOG_A;        // RULE10
        end
      end
      `AOC_PAT_RAMP:   o_word = ramp_q;                    // RULE12
      `AOC_PAT_CUSTOM: o_word = i_custom;                  // RULE13
      default:         o_word = '0;
    endcase
  end

  // register pattern state
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      tog_q  <= 1'b0;
      div_q  <= '0;
      ramp_q <= '0;
    end else begin
      tog_q  <= tog_d;
      div_q  <= div_d;
      ramp_q <= ramp_d;
    end
  end

  sequence s_ramp_tick;
    is_ramp && div_q == `AOC_RAMP_LAST;
  endsequence

  a_ramp_step: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE12
    s_ramp_tick ##1 is_ramp |-> ramp_q == 11'($past(ramp_q) + 11'h001))
    else $error("ramp did not step after eight cycles");

  a_ramp_hold: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE18
    is_ramp && div_q != `AOC_RAMP_LAST ##1 is_ramp |-> $stable(ramp_q))
    else $error("ramp moved between steps");

  a_toggle_alt: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE10
    i_pat == `AOC_PAT_TOGGLE && i_take ##1 i_pat == `AOC_PAT_TOGGLE
      && $stable(i_narrow) |-> o_word[8:0] == ~$past(o_word[8:0]))
    else $error("toggle word did not alternate");

  a_fixed_levels: assert property (@(posedge i_clk) disable iff (!i_rst_n) // RULE9
    i_pat == `AOC_PAT_ONES |-> o_word == 11'h7FF)
    else $error("all-ones pattern wrong");
endmodule : aoc_pattern_gen
`default_nettype wire

// ---- src/aoc_pkg.sv ----
// aoc_pkg.sv: types shared by the output configuration bank.
// assumes: aoc_map.svh sits on the include path.
`default_nettype none
package aoc_pkg;
  `include "aoc_map.svh"

  // decoded output swing level
  typedef enum logic [2:0] {
    AOC_SWING_350,
    AOC_SWING_410,
    AOC_SWING_465,
    AOC_SWING_570,
    AOC_SWING_125
  } aoc_swing_t;

  typedef logic [10:0] aoc_word_t;   // output data word
endpackage : aoc_pkg
`default_nettype wire

// ---- src/aoc_skid2.sv ----
// aoc_skid2.sv: two-entry buffer with valid/ready on both sides.
// assumes: one clock, synchronous active-low reset.
`default_nettype none
module aoc_skid2 #(
  parameter int W = 11                  // data width
) (
  input  wire logic         i_clk,      // clock
  input  wire logic         i_rst_n,    // sync reset, low active
  input  wire logic [W-1:0] i_data,     // word in
  input  wire logic         i_valid,    // word in valid
  output logic              o_ready,    // room for a word
  output logic      [W-1:0] o_data,     // head word
  output logic              o_valid,    // head valid
  input  wire logic         i_ready     // receiver takes head
);
  logic [W-1:0] head_q, head_d;         // entry presented outward
  logic [W-1:0] spare_q, spare_d;       // overflow entry
  logic         hv_q, hv_d;             // head valid
  logic         sv_q, sv_d;             // spare valid
  logic         push, pop;              // handshakes

  assign o_ready = ~sv_q;
  assign o_valid = hv_q;
  assign o_data  = head_q;
  assign push    = i_valid & ~sv_q;
  assign pop     = hv_q & i_ready;

  // next entry contents; the spare only fills while the head stalls
  always_comb begin
    head_d  = head_q;
    spare_d = spare_q;
    hv_d    = hv_q;
    sv_d    = sv_q;
    if (pop) begin
      if (sv_q) begin
        head_d = spare_q;
        sv_d   = 1'b0;
      end else if (push) begin
        head_d = i_data;
      end else begin
        hv_d = 1'b0;
      end
    end else if (push) begin
      if (!hv_q) begin
        head_d = i_data;
        hv_d   = 1'b1;
      end else begin
        spare_d = i_data;
        sv_d    = 1'b1;
      end
    end
  end

  // register entries
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      head_q  <= '0;
      spare_q <= '0;
      hv_q    <= 1'b0;
      sv_q    <= 1'b0;
    end else begin
      head_q  <= head_d;
      spare_q <= spare_d;
      hv_q    <= hv_d;
      sv_q    <= sv_d;
    end
  end
endmodule : aoc_skid2
`default_nettype wire
